// ---- rtl/lfib_regs.sv ----
// fault flags, interrupt, backlight config, sink grouping and off timeout
// assumes a serial slave front end giving decoded byte reads and writes
// Operation
// - short detector sets flag bit 4
// - thermal detector sets flag bit 3
// - overvoltage detector sets flag bit 2
// - flag held until host writes one
// - writing zero or reading keeps flags
// - enabled set flag raises host interrupt
// - disabled flag still latches, no interrupt
// - bits 2:1 select transfer law
// - bit 0 enables fade override
// - selector bit one makes sink independent
// - backlight turns off after off timeout
// - off count follows expired dim timeout
// - zero disables, N means N seconds
// - int config releases output 50 us
// - group sinks need enable and active
// - dim count starts at maximum current
`timescale 1ns/1ps
`default_nettype none
`include "lfib_cfg.svh"
module lfib_regs #(
  parameter int unsigned SEC_CYCLES = `LFIB_SEC_CYC,
  parameter int unsigned REL_CYCLES = `LFIB_REL_CYC
)(
  // clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       NRST_IN,
  // register access
  input  wire logic       WR_EN_IN,
  input  wire logic       RD_EN_IN,
  input  wire logic [7:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  output logic      [7:0] RDATA_OUT,
  // fault detectors
  input  wire logic       SHORT_DET_IN,
  input  wire logic       THERM_DET_IN,
  input  wire logic       OVP_DET_IN,
  // mode inputs
  input  wire logic       BL_ON_IN,
  input  wire logic       ACTIVE_NOT_STANDBY_IN,
  input  wire logic       INT_CFG_IN,
  input  wire logic [6:0] DIM_DELAY_IN,
  input  wire logic       BL_AT_MAX_IN,
  // outputs
  output logic            IRQ_OUT,
  output logic            BL_LIT_OUT,
  output logic            BL_DIM_OUT,
  output logic      [6:0] GROUP_SINK_ON_OUT,
  output logic      [6:0] INDEP_SINK_OUT,
  output logic      [1:0] LAW_OUT,
  output logic            FADE_OVR_OUT
);
  function automatic logic hit(input logic wr, input logic [7:0] a, input logic [7:0] off);
    return wr && (a == off);
  endfunction

  lfib_pkg::lfib_byte_t flt_r, ien_r, cfg_r, sel_r, off_r;
  lfib_pkg::lfib_byte_t flt_nxt, ien_nxt, cfg_nxt, sel_nxt, off_nxt, rd_nxt;
  lfib_pkg::lfib_byte_t det;
  lfib_pkg::lfib_bl_e   st_r, st_nxt;
  logic [6:0] sec_r, sec_nxt, lim;
  logic       rel_r, rel_nxt, irq_nxt, clr_evt, sec_tick, rel_tick, en, lit_nxt;

  // fault latches and register writes
  always_comb begin
    det = `LFIB_RST_BYTE;
    det[`LFIB_BIT_SHORT] = SHORT_DET_IN;
    det[`LFIB_BIT_THERM] = THERM_DET_IN;
    det[`LFIB_BIT_OVP]   = OVP_DET_IN;
    flt_nxt = flt_r;
    if (hit(WR_EN_IN, ADDR_IN, `LFIB_ADDR_FLT)) begin
      flt_nxt = flt_r & ~(WDATA_IN & `LFIB_MASK_FLT);
    end
    flt_nxt = flt_nxt | det;
    ien_nxt = hit(WR_EN_IN, ADDR_IN, `LFIB_ADDR_IEN) ? (WDATA_IN & `LFIB_MASK_FLT) : ien_r;
    cfg_nxt = hit(WR_EN_IN, ADDR_IN, `LFIB_ADDR_CFG) ? (WDATA_IN & `LFIB_MASK_CFG) : cfg_r;
    sel_nxt = hit(WR_EN_IN, ADDR_IN, `LFIB_ADDR_SEL) ? (WDATA_IN & `LFIB_MASK_7B) : sel_r;
    off_nxt = hit(WR_EN_IN, ADDR_IN, `LFIB_ADDR_OFF) ? (WDATA_IN & `LFIB_MASK_7B) : off_r;
    rd_nxt = RDATA_OUT;
    if (RD_EN_IN) begin
      case (ADDR_IN)
        `LFIB_ADDR_FLT: rd_nxt = flt_r;
        `LFIB_ADDR_IEN: rd_nxt = ien_r;
        `LFIB_ADDR_CFG: rd_nxt = cfg_r;
        `LFIB_ADDR_SEL: rd_nxt = sel_r;
        `LFIB_ADDR_OFF: rd_nxt = off_r;
        default:        rd_nxt = `LFIB_RST_BYTE;
      endcase
    end
  end

  // interrupt output with release window
  always_comb begin
    clr_evt = hit(WR_EN_IN, ADDR_IN, `LFIB_ADDR_FLT) &&
              ((WDATA_IN & flt_r & `LFIB_MASK_FLT) != `LFIB_RST_BYTE);
    rel_nxt = rel_r;
    if (rel_r && rel_tick) begin
      rel_nxt = 1'b0;
    end
    if (clr_evt && INT_CFG_IN && ((flt_nxt & ien_nxt) != `LFIB_RST_BYTE)) begin
      rel_nxt = 1'b1;
    end
    irq_nxt = ((flt_nxt & ien_nxt) != `LFIB_RST_BYTE) && !rel_nxt;
  end

  lfib_tick #(.DIV(REL_CYCLES)) u_rel_tick (
    .clk_in   (CLK_IN),
    .nrst_in  (NRST_IN),
    .clr_in   (clr_evt),
    .run_in   (rel_r),
    .tick_out (rel_tick)
  );

  // backlight timeout sequencer
  always_comb begin
    en      = BL_ON_IN && ACTIVE_NOT_STANDBY_IN;
    st_nxt  = st_r;
    sec_nxt = sec_r;
    lim     = `LFIB_RST_SEC;
    case (st_r)
      lfib_pkg::BL_IDLE: begin
        sec_nxt = `LFIB_RST_SEC;
        if (en) begin
          st_nxt = lfib_pkg::BL_FULL;
        end
      end
      lfib_pkg::BL_FULL: begin
        lim = (DIM_DELAY_IN != `LFIB_RST_SEC) ? DIM_DELAY_IN : off_r[6:0];
        if (lim != `LFIB_RST_SEC && BL_AT_MAX_IN && sec_tick) begin
          sec_nxt = sec_r + `LFIB_SEC_ONE;
          if (sec_nxt == lim) begin
            sec_nxt = `LFIB_RST_SEC;
            st_nxt  = (DIM_DELAY_IN != `LFIB_RST_SEC) ? lfib_pkg::BL_DIM : lfib_pkg::BL_DONE;
          end
        end
      end
      lfib_pkg::BL_DIM: begin
        lim = off_r[6:0];
        if (lim != `LFIB_RST_SEC && sec_tick) begin
          sec_nxt = sec_r + `LFIB_SEC_ONE;
          if (sec_nxt == lim) begin
            sec_nxt = `LFIB_RST_SEC;
            st_nxt  = lfib_pkg::BL_DONE;
          end
        end
      end
      lfib_pkg::BL_DONE: sec_nxt = `LFIB_RST_SEC;
      default: st_nxt = lfib_pkg::BL_IDLE;
    endcase
    if (!en) begin
      st_nxt = lfib_pkg::BL_IDLE;
    end
    lit_nxt = (st_nxt == lfib_pkg::BL_FULL) || (st_nxt == lfib_pkg::BL_DIM);
  end

  lfib_tick #(.DIV(SEC_CYCLES)) u_sec_tick (
    .clk_in   (CLK_IN),
    .nrst_in  (NRST_IN),
    .clr_in   (st_nxt != st_r),
    .run_in   ((st_r == lfib_pkg::BL_FULL && BL_AT_MAX_IN) || st_r == lfib_pkg::BL_DIM),
    .tick_out (sec_tick)
  );

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      flt_r             <= `LFIB_RST_BYTE;
      ien_r             <= `LFIB_RST_BYTE;
      cfg_r             <= `LFIB_RST_BYTE;
      sel_r             <= `LFIB_RST_BYTE;
      off_r             <= `LFIB_RST_BYTE;
      RDATA_OUT         <= `LFIB_RST_BYTE;
      rel_r             <= 1'b0;
      IRQ_OUT           <= 1'b0;
      st_r              <= lfib_pkg::BL_IDLE;
      sec_r             <= `LFIB_RST_SEC;
      BL_LIT_OUT        <= 1'b0;
      BL_DIM_OUT        <= 1'b0;
      GROUP_SINK_ON_OUT <= `LFIB_RST_SEC;
    end else begin
      flt_r             <= flt_nxt;
      ien_r             <= ien_nxt;
      cfg_r             <= cfg_nxt;
      sel_r             <= sel_nxt;
      off_r             <= off_nxt;
      RDATA_OUT         <= rd_nxt;
      rel_r             <= rel_nxt;
      IRQ_OUT           <= irq_nxt;
      st_r              <= st_nxt;
      sec_r             <= sec_nxt;
      BL_LIT_OUT        <= lit_nxt;
      BL_DIM_OUT        <= (st_nxt == lfib_pkg::BL_DIM);
      GROUP_SINK_ON_OUT <= {7{lit_nxt}} & ~sel_nxt[6:0];
    end
  end

  assign INDEP_SINK_OUT = sel_r[6:0];
  assign LAW_OUT        = cfg_r[`LFIB_LAW_HI:`LFIB_LAW_LO];
  assign FADE_OVR_OUT   = cfg_r[`LFIB_BIT_FADE_OVERRIDE];

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);

  a_short_flag_set: assert property (SHORT_DET_IN |=> flt_r[`LFIB_BIT_SHORT])
    else $error("short flag not set");
  a_therm_flag_set: assert property (THERM_DET_IN |=> flt_r[`LFIB_BIT_THERM])
    else $error("thermal flag not set");
  a_ovp_flag_set: assert property (OVP_DET_IN |=> flt_r[`LFIB_BIT_OVP])
    else $error("overvoltage flag not set");
  a_flag_w1c_clear: assert property (
    (hit(WR_EN_IN, ADDR_IN, `LFIB_ADDR_FLT) && WDATA_IN[`LFIB_BIT_SHORT] && !SHORT_DET_IN)
    |=> !flt_r[`LFIB_BIT_SHORT])
    else $error("flag not cleared by one");
  a_flag_hold_zero: assert property (
    (flt_r[`LFIB_BIT_THERM] &&
     !(hit(WR_EN_IN, ADDR_IN, `LFIB_ADDR_FLT) && WDATA_IN[`LFIB_BIT_THERM]))
    |=> flt_r[`LFIB_BIT_THERM])
    else $error("flag lost without clear");
  a_irq_follows_flags: assert property (IRQ_OUT == (((flt_r & ien_r) != 8'h00) && !rel_r))
    else $error("interrupt does not match flags");
  a_irq_masked_quiet: assert property (((flt_r & ien_r) == 8'h00) |-> !IRQ_OUT)
    else $error("interrupt from disabled flag");
  a_release_hold: assert property ($rose(rel_r) |-> (rel_r && !IRQ_OUT)[*8])
    else $error("release window too short");
  a_group_excl: assert property ((GROUP_SINK_ON_OUT & INDEP_SINK_OUT) == 7'h00)
    else $error("independent sink lit as group");
  a_standby_dark: assert property (!ACTIVE_NOT_STANDBY_IN |=> !BL_LIT_OUT && GROUP_SINK_ON_OUT == 7'h00)
    else $error("backlight lit in standby");
  a_reserved_zero: assert property (
    ((flt_r | ien_r) & ~`LFIB_MASK_FLT) == `LFIB_RST_BYTE &&
    (cfg_r & ~`LFIB_MASK_CFG) == `LFIB_RST_BYTE &&
    ((sel_r | off_r) & ~`LFIB_MASK_7B) == `LFIB_RST_BYTE)
    else $error("reserved bit set");

  c_irq_raised: cover property ($rose(IRQ_OUT));
  c_release: cover property ($rose(rel_r));
  c_dim_reached: cover property ($rose(BL_DIM_OUT));
  c_off_timeout: cover property (st_r == lfib_pkg::BL_DONE);
endmodule
`default_nettype wire

// ---- pkg/lfib_cfg.svh ----
// constants of the fault, interrupt and backlight register block
// assumes a 100 MHz clock
`ifndef LFIB_CFG_SVH
`define LFIB_CFG_SVH
`define LFIB_ADDR_FLT     8'h02
`define LFIB_ADDR_IEN     8'h03
`define LFIB_ADDR_CFG     8'h04
`define LFIB_ADDR_SEL     8'h05
`define LFIB_ADDR_OFF     8'h06
`define LFIB_BIT_SHORT   4
`define LFIB_BIT_THERM   3
`define LFIB_BIT_OVP     2
`define LFIB_MASK_FLT     8'h1c
`define LFIB_MASK_CFG     8'h07
`define LFIB_MASK_7B      8'h7f
`define LFIB_RST_BYTE     8'h00
`define LFIB_RST_SEC      7'h00
`define LFIB_SEC_ONE      7'h01
`define LFIB_BIT_FADE_OVERRIDE    0
`define LFIB_LAW_HI      2
`define LFIB_LAW_LO      1
`define LFIB_CLK_NS      10
`define LFIB_SEC_NS      1000000000
`define LFIB_REL_NS      50000
`define LFIB_SEC_CYC     (`LFIB_SEC_NS / `LFIB_CLK_NS)
`define LFIB_REL_CYC     (`LFIB_REL_NS / `LFIB_CLK_NS)
`endif

// ---- pkg/lfib_pkg.sv ----
// types of the fault, interrupt and backlight register block
// assumes nothing beyond the cfg header
package lfib_pkg;
  typedef enum logic [1:0] {BL_IDLE, BL_FULL, BL_DIM, BL_DONE} lfib_bl_e;
  typedef logic [7:0] lfib_byte_t;
endpackage

// ---- rtl/lfib_tick.sv ----
// cycle divider giving a one-cycle tick every DIV cycles
// assumes one clock; clear restarts the count
`timescale 1ns/1ps
`default_nettype none
module lfib_tick #(
  parameter int unsigned DIV = 2
)(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // control
  input  wire logic clr_in,
  input  wire logic run_in,
  // tick
  output logic      tick_out
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        tick_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (clr_in) begin
      cnt_nxt = 32'h0;
    end else if (run_in) begin
      if (cnt_r == 32'(DIV - 1)) begin
        cnt_nxt  = 32'h0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_r    <= 32'h0;
      tick_out <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      tick_out <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- verif/lfib_host.sv ----
// host model: byte reads and writes on the decoded register port
// assumes the port samples requests on rising clock edges
`timescale 1ns/1ps
`default_nettype none
module lfib_host (
  // clock
  input  wire logic       clk_in,
  // register port
  output logic            wr_out,
  output logic            rd_out,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  input  wire logic [7:0] rdata_in
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'hff;
    wdata_out = 8'hff;
  end
  // one-cycle write strobe, released lines inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    rd_out = 1'b1;
    addr_out = a;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// ---- verif/test_led_fault_irq_backlight_regs.sv ----
// testbench of the fault, interrupt and backlight register block
// assumes short second and release counts set by parameter
`timescale 1ns/1ps
`default_nettype none
`include "lfib_cfg.svh"
module test_led_fault_irq_backlight_regs;
  localparam int SEC = 20;
  localparam int REL = 10;
  logic       clk, nrst, sdet, tdet, odet, bl_on, act, icfg, at_max;
  logic       wr, rd, irq, lit, dim, fade_override;
  logic [7:0] addr, wdata, rdata, d;
  logic [6:0] ddly, grp, indep;
  logic [1:0] law;
  logic [7:0] msk [4] = '{8'h1c, 8'h07, 8'h7f, 8'h7f};
  int         fails, cmp_count, c;
  lfib_host host_u (.clk_in(clk), .wr_out(wr), .rd_out(rd), .addr_out(addr),
    .wdata_out(wdata), .rdata_in(rdata));
  lfib_regs #(.SEC_CYCLES(SEC), .REL_CYCLES(REL)) dut_u (.CLK_IN(clk), .NRST_IN(nrst),
    .WR_EN_IN(wr), .RD_EN_IN(rd), .ADDR_IN(addr), .WDATA_IN(wdata), .RDATA_OUT(rdata),
    .SHORT_DET_IN(sdet), .THERM_DET_IN(tdet), .OVP_DET_IN(odet), .BL_ON_IN(bl_on),
    .ACTIVE_NOT_STANDBY_IN(act), .INT_CFG_IN(icfg), .DIM_DELAY_IN(ddly),
    .BL_AT_MAX_IN(at_max), .IRQ_OUT(irq), .BL_LIT_OUT(lit), .BL_DIM_OUT(dim),
    .GROUP_SINK_ON_OUT(grp), .INDEP_SINK_OUT(indep), .LAW_OUT(law), .FADE_OVR_OUT(fade_override));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk(d, e);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic pulse(input logic [2:0] v);
    {sdet, tdet, odet} = v;
    cyc(1);
    {sdet, tdet, odet} = 3'h0;
    cyc(1);
  endtask
  task automatic wait_on(input logic sel_dim, input logic v);
    c = 0;
    while (((sel_dim ? dim : lit) !== v) && c < 400) begin
      @(negedge clk);
      c++;
    end
    if (c >= 400) begin
      fails++;
      give_verdict();
    end
  endtask
  initial begin
    {nrst, sdet, tdet, odet, bl_on, act, icfg, at_max} = 8'h00;
    ddly = 7'h00;
    fails = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    for (int a = 2; a <= 7; a++) rchk(8'(a), 8'h00);
    host_u.wr(8'h07, 8'hff);
    rchk(8'h07, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(8'(i + 3), 8'hff);
      rchk(8'(i + 3), msk[i]);
    end
    chk({1'b0, indep}, 8'h7f);
    chk({5'h00, law, fade_override}, 8'h07);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(`LFIB_ADDR_CFG, 8'(i * 2));
      cyc(1);
      chk({5'h00, law, fade_override}, 8'(i * 2));
    end
    host_u.wr(`LFIB_ADDR_IEN, 8'h00);
    for (int b = 2; b <= 4; b++) begin
      pulse(3'(1 << (b - 2)));
      chk({7'h00, irq}, 8'h00);
      rchk(`LFIB_ADDR_FLT, 8'(1 << b));
      host_u.wr(`LFIB_ADDR_FLT, ~8'(1 << b));
      rchk(`LFIB_ADDR_FLT, 8'(1 << b));
      host_u.wr(`LFIB_ADDR_IEN, 8'(1 << b));
      cyc(1);
      chk({7'h00, irq}, 8'h01);
      host_u.wr(`LFIB_ADDR_FLT, 8'(1 << b));
      cyc(1);
      chk({7'h00, irq}, 8'h00);
      rchk(`LFIB_ADDR_FLT, 8'h00);
      host_u.wr(`LFIB_ADDR_IEN, 8'h00);
    end
    icfg = 1'b1;
    host_u.wr(`LFIB_ADDR_IEN, 8'h1c);
    pulse(3'b110);
    chk({7'h00, irq}, 8'h01);
    host_u.wr(`LFIB_ADDR_FLT, 8'h10);
    chk({7'h00, irq}, 8'h00);
    cyc(REL - 2);
    chk({7'h00, irq}, 8'h00);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    icfg = 1'b0;
    pulse(3'b001);
    host_u.wr(`LFIB_ADDR_FLT, 8'h08);
    chk({7'h00, irq}, 8'h01);
    host_u.wr(`LFIB_ADDR_FLT, 8'h1c);
    host_u.wr(`LFIB_ADDR_SEL, 8'h0f);
    host_u.wr(`LFIB_ADDR_OFF, 8'h02);
    ddly = 7'h01;
    {act, bl_on} = 2'b11;
    cyc(2);
    chk({1'b0, grp}, 8'h70);
    cyc(2 * SEC);
    chk({7'h00, dim}, 8'h00);
    at_max = 1'b1;
    wait_on(1'b1, 1'b1);
    chk(8'(c >= SEC - 2 && c <= SEC + 3), 8'h01);
    wait_on(1'b0, 1'b0);
    chk(8'(c >= 2 * SEC - 2 && c <= 2 * SEC + 3), 8'h01);
    chk({1'b0, grp}, 8'h00);
    bl_on = 1'b0;
    host_u.wr(`LFIB_ADDR_OFF, 8'h00);
    ddly = 7'h00;
    bl_on = 1'b1;
    cyc(2);
    chk({7'h00, lit}, 8'h01);
    cyc(8 * SEC);
    chk({7'h00, lit}, 8'h01);
    act = 1'b0;
    cyc(2);
    chk({lit, grp}, 8'h00);
    nrst = 1'b0;
    cyc(1);
    chk({1'b0, indep}, 8'h00);
    nrst = 1'b1;
    rchk(`LFIB_ADDR_SEL, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
